// ---- pih_pkg.sv ----
package pih_pkg;
  localparam int NSRC = 22;
  localparam int ORD_W = 5;
  localparam logic [7:0] OFF_IE = 8'h00;
  localparam logic [7:0] OFF_IP = 8'h04;
  localparam logic [7:0] OFF_EIE1 = 8'h08;
  localparam logic [7:0] OFF_EIP1 = 8'h0c;
  localparam logic [7:0] OFF_EIE2 = 8'h10;
  localparam logic [7:0] OFF_EIP2 = 8'h14;
  localparam logic [7:0] OFF_TCTL = 8'h18;
  localparam logic [7:0] OFF_EXTCFG = 8'h1c;
  localparam logic [7:0] OFF_PEND = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam int GATE_BIT = 7;
  localparam int TCTL_EZ_EDGE = 0;
  localparam int TCTL_EZ_PEND = 1;
  localparam int TCTL_EN_EDGE = 2;
  localparam int TCTL_EN_PEND = 3;
  localparam int CFG_EZ_POL = 0;
  localparam int CFG_EN_POL = 1;
  localparam int ORD_EXT_ZERO = 0;
  localparam int ORD_ENABLE_PIN = 6;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IP_RESET = 8'h80;
  localparam logic [7:0] EIE_RESET = 8'h00;
  localparam logic [7:0] EIP_RESET = 8'h00;
  // Self-clearing sources: orders 0 1 2 6 9 11 15 17 20
  localparam logic [NSRC-1:0] SELF_CLEAR = 22'h128a47;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int CALL_CYCLES = 5;
  localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

  typedef enum logic [1:0] {PIH_IDLE, PIH_CALL} pih_state_e;

  typedef struct packed {
    logic call_active;
    logic vector_taken;
    logic [15:0] vector_addr;
  } pih_cpu_s;

  typedef struct packed {
    logic instr_done;
    logic return_from_isr;
  } pih_core_s;
endpackage

// ---- pih_top.sv ----
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module pih_top (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [pih_pkg::NSRC-1:0] SRC_EVENT,
  input wire logic EXT_ZERO_PIN,
  input wire logic ENABLE_PIN,
  input wire pih_pkg::pih_core_s CORE_IN,
  output logic IRQ_REQ,
  output pih_pkg::pih_cpu_s CPU_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [pih_pkg::ORD_W-1:0] first_set(input logic [pih_pkg::NSRC-1:0] v);
    logic [pih_pkg::ORD_W-1:0] r;
    r = '0;
    for (int i = pih_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = pih_pkg::ORD_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vec_of(input logic [pih_pkg::ORD_W-1:0] ord);
    return pih_pkg::VEC_BASE + (16'(ord) << pih_pkg::VEC_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ie_q, ip_q, eie1_q, eip1_q, eie2_q, eip2_q;
  logic ez_edge_q, en_edge_q, ez_pol_q, en_pol_q;
  logic [pih_pkg::NSRC-1:0] pend_q, pend_d;
  logic ez_prev_q, en_prev_q;
  logic cand_q;
  logic [pih_pkg::ORD_W-1:0] cand_ord_q;
  logic in_hi_q, in_lo_q, inhibit_q;
  pih_pkg::pih_state_e state_q;
  logic [2:0] cnt_q;
  logic hi_busy, lo_busy;
  logic taken_q;
  logic [15:0] vaddr_q;
  logic [31:0] prdata_q;
  logic setup, access, wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic [pih_pkg::NSRC-1:0] en_vec, pri_vec, req, req_hi, req_lo, hw_set;
  logic ez_act, en_act, ez_edge, en_edge;
  logic cand_d, take;
  logic [pih_pkg::ORD_W-1:0] cand_ord_d;

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and read data
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    if (PADDR == pih_pkg::OFF_IE)
      rd_mux = {24'h000000, ie_q};
    else if (PADDR == pih_pkg::OFF_IP)
      rd_mux = {24'h000000, ip_q};
    else if (PADDR == pih_pkg::OFF_EIE1)
      rd_mux = {24'h000000, eie1_q};
    else if (PADDR == pih_pkg::OFF_EIP1)
      rd_mux = {24'h000000, eip1_q};
    else if (PADDR == pih_pkg::OFF_EIE2)
      rd_mux = {24'h000000, eie2_q};
    else if (PADDR == pih_pkg::OFF_EIP2)
      rd_mux = {24'h000000, eip2_q};
    else if (PADDR == pih_pkg::OFF_TCTL)
    begin
      rd_mux[pih_pkg::TCTL_EZ_EDGE] = ez_edge_q;
      rd_mux[pih_pkg::TCTL_EZ_PEND] = pend_q[pih_pkg::ORD_EXT_ZERO];
      rd_mux[pih_pkg::TCTL_EN_EDGE] = en_edge_q;
      rd_mux[pih_pkg::TCTL_EN_PEND] = pend_q[pih_pkg::ORD_ENABLE_PIN];
    end
    else if (PADDR == pih_pkg::OFF_EXTCFG)
    begin
      rd_mux[pih_pkg::CFG_EZ_POL] = ez_pol_q;
      rd_mux[pih_pkg::CFG_EN_POL] = en_pol_q;
    end
    else if (PADDR == pih_pkg::OFF_PEND)
      rd_mux = {10'h000, pend_q};
    else if (PADDR == pih_pkg::OFF_STAT)
      rd_mux = {22'h000000, cand_q, cand_ord_q, state_q == pih_pkg::PIH_CALL, inhibit_q, in_hi_q, in_lo_q};
    else
      mapped = 1'b0;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      prdata_q <= '0;
    else if (CE && setup)
      prdata_q <= PWRITE ? 32'h00000000 : rd_mux;
  end

  assign PRDATA = prdata_q;
  assign PREADY = access;
  assign PSLVERR = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Enable, priority and pin configuration registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ie_q <= pih_pkg::IE_RESET;
      ip_q <= pih_pkg::IP_RESET;
      eie1_q <= pih_pkg::EIE_RESET;
      eip1_q <= pih_pkg::EIP_RESET;
      eie2_q <= pih_pkg::EIE_RESET;
      eip2_q <= pih_pkg::EIP_RESET;
      ez_edge_q <= 1'b0;
      en_edge_q <= 1'b0;
      ez_pol_q <= 1'b0;
      en_pol_q <= 1'b0;
    end
    else if (CE && wr)
    begin
      if (PADDR == pih_pkg::OFF_IE)
        ie_q <= PWDATA[7:0];
      else if (PADDR == pih_pkg::OFF_IP)
        ip_q <= PWDATA[7:0] | pih_pkg::IP_RESET;
      else if (PADDR == pih_pkg::OFF_EIE1)
        eie1_q <= PWDATA[7:0];
      else if (PADDR == pih_pkg::OFF_EIP1)
        eip1_q <= PWDATA[7:0];
      else if (PADDR == pih_pkg::OFF_EIE2)
        eie2_q <= {1'b0, PWDATA[6:0]};
      else if (PADDR == pih_pkg::OFF_EIP2)
        eip2_q <= {1'b0, PWDATA[6:0]};
      else if (PADDR == pih_pkg::OFF_TCTL)
      begin
        ez_edge_q <= PWDATA[pih_pkg::TCTL_EZ_EDGE];
        en_edge_q <= PWDATA[pih_pkg::TCTL_EN_EDGE];
      end
      else if (PADDR == pih_pkg::OFF_EXTCFG)
      begin
        ez_pol_q <= PWDATA[pih_pkg::CFG_EZ_POL];
        en_pol_q <= PWDATA[pih_pkg::CFG_EN_POL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External input conditioning, pins only observed
  assign ez_act = ez_pol_q ? EXT_ZERO_PIN : ~EXT_ZERO_PIN;
  assign en_act = en_pol_q ? ENABLE_PIN : ~ENABLE_PIN;
  assign ez_edge = ez_act & ~ez_prev_q;
  assign en_edge = en_act & ~en_prev_q;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      ez_prev_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else if (CE)
    begin
      ez_prev_q <= ez_act;
      en_prev_q <= en_act;
    end
  end

  always_comb
  begin
    hw_set = SRC_EVENT;
    hw_set[pih_pkg::ORD_EXT_ZERO] = ez_edge_q & ez_edge;
    hw_set[pih_pkg::ORD_ENABLE_PIN] = en_edge_q & en_edge;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags
  always_comb
  begin
    pend_d = pend_q;
    if (wr && PADDR == pih_pkg::OFF_PEND)
      pend_d = PWDATA[pih_pkg::NSRC-1:0];
    else if (wr && PADDR == pih_pkg::OFF_TCTL)
    begin
      pend_d[pih_pkg::ORD_EXT_ZERO] = PWDATA[pih_pkg::TCTL_EZ_PEND];
      pend_d[pih_pkg::ORD_ENABLE_PIN] = PWDATA[pih_pkg::TCTL_EN_PEND];
    end
    if (take && pih_pkg::SELF_CLEAR[cand_ord_q])
      pend_d[cand_ord_q] = 1'b0;
    pend_d = pend_d | hw_set;
    if (!ez_edge_q)
      pend_d[pih_pkg::ORD_EXT_ZERO] = ez_act;
    if (!en_edge_q)
      pend_d[pih_pkg::ORD_ENABLE_PIN] = en_act;
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      pend_q <= '0;
    else if (CE)
      pend_q <= pend_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle sampling and priority decode
  assign en_vec = {eie2_q[6:0], eie1_q, ie_q[6:0]};
  assign pri_vec = {eip2_q[6:0], eip1_q, ip_q[6:0]};
  assign req = pend_q & en_vec & {pih_pkg::NSRC{ie_q[pih_pkg::GATE_BIT]}};
  assign req_hi = req & pri_vec;
  assign req_lo = req & ~pri_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Service levels seen by the decode; a return frees its level this cycle
  always_comb
  begin
    hi_busy = in_hi_q;
    lo_busy = in_lo_q;
    if (CORE_IN.return_from_isr)
    begin
      if (in_hi_q)
        hi_busy = 1'b0;
      else
        lo_busy = 1'b0;
    end
  end

  always_comb
  begin
    cand_d = 1'b0;
    cand_ord_d = '0;
    if (hi_busy)
      cand_d = 1'b0;
    else if (req_hi != '0)
    begin
      cand_d = 1'b1;
      cand_ord_d = first_set(req_hi);
    end
    else if (!lo_busy && req_lo != '0)
    begin
      cand_d = 1'b1;
      cand_ord_d = first_set(req_lo);
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      cand_q <= 1'b0;
      cand_ord_q <= '0;
    end
    else if (CE)
    begin
      cand_q <= cand_d & ~take;
      cand_ord_q <= cand_ord_d;
    end
  end

  assign IRQ_REQ = cand_q;

  // Vector taken at any instruction end, the first one after a return too
  assign take = cand_q & CORE_IN.instr_done & (state_q == pih_pkg::PIH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Return tracking and in-service levels
  // Post-return flag is status only: that instruction may still take a vector
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      inhibit_q <= 1'b0;
    else if (CE)
    begin
      if (CORE_IN.return_from_isr)
        inhibit_q <= 1'b1;
      else if (CORE_IN.instr_done)
        inhibit_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
    end
    else if (CE)
    begin
      if (take)
      begin
        if (pri_vec[cand_ord_q])
          in_hi_q <= 1'b1;
        else
          in_lo_q <= 1'b1;
      end
      else if (CORE_IN.return_from_isr)
      begin
        if (in_hi_q)
          in_hi_q <= 1'b0;
        else
          in_lo_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Long call sequencing
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= pih_pkg::PIH_IDLE;
      cnt_q <= '0;
      taken_q <= 1'b0;
      vaddr_q <= '0;
    end
    else if (CE)
    begin
      taken_q <= 1'b0;
      case (state_q)
        pih_pkg::PIH_IDLE:
        begin
          if (take)
          begin
            state_q <= pih_pkg::PIH_CALL;
            cnt_q <= '0;
            vaddr_q <= vec_of(cand_ord_q);
          end
        end
        pih_pkg::PIH_CALL:
        begin
          if (cnt_q == pih_pkg::CALL_LAST)
          begin
            state_q <= pih_pkg::PIH_IDLE;
            taken_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q + 3'h1;
        end
        default:
          state_q <= pih_pkg::PIH_IDLE;
      endcase
    end
  end

  assign CPU_OUT.call_active = (state_q == pih_pkg::PIH_CALL);
  assign CPU_OUT.vector_taken = taken_q;
  assign CPU_OUT.vector_addr = vaddr_q;

endmodule // pih_top

// ---- pih_asserts.sv ----
`timescale 1ns/1ns
module pih_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic IRQ_REQ,
  input wire pih_pkg::pih_core_s CORE_IN,
  input wire pih_pkg::pih_cpu_s CPU_OUT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_CALL_LEN: assert property ($rose(CPU_OUT.call_active) |-> CPU_OUT.call_active[*5] ##1 !CPU_OUT.call_active)
    else $error("call length wrong");
  AST_VEC_AFTER: assert property ($rose(CPU_OUT.call_active) |-> ##5 CPU_OUT.vector_taken)
    else $error("vector strobe late");
  AST_TAKE_CAUSE: assert property ($rose(CPU_OUT.call_active) |-> $past(IRQ_REQ) && $past(CORE_IN.instr_done))
    else $error("call without request");
  AST_REQ_DROP: assert property ($rose(CPU_OUT.call_active) |-> !IRQ_REQ)
    else $error("request kept after take");
  AST_VEC_ALIGN: assert property (CPU_OUT.call_active |-> CPU_OUT.vector_addr[2:0] == 3'h3 && CPU_OUT.vector_addr <= 16'h00ab)
    else $error("vector off table");
  AST_VEC_STABLE: assert property (CPU_OUT.call_active && $past(CPU_OUT.call_active) |-> $stable(CPU_OUT.vector_addr))
    else $error("vector moved in call");
  AST_VT_ONE: assert property (CPU_OUT.vector_taken |=> !CPU_OUT.vector_taken)
    else $error("vector strobe too long");
  AST_RESET_VEC: assert property ($fell(RST) |-> CPU_OUT.vector_addr == 16'h0000)
    else $error("reset vector not zero");
endmodule // pih_checker
////////////////////////////////////////
bind pih_top pih_checker i_pih_checker (.MCLK(MCLK), .RST(RST), .IRQ_REQ(IRQ_REQ), .CORE_IN(CORE_IN), .CPU_OUT(CPU_OUT));

// ---- pih_core_model.sv ----
`timescale 1ns/1ns
module pih_core_model (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [3:0] isr_len,
  input wire logic [3:0] div_len,
  input wire pih_pkg::pih_cpu_s CPU_OUT,
  output pih_pkg::pih_core_s CORE_IN
);
  logic [3:0] rem_q [4];
  logic [1:0] dep_q;
  logic [3:0] wait_q;
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CORE_IN <= '0;
      dep_q <= '0;
      wait_q <= '0;
    end
    else
    begin
      CORE_IN <= '0;
      if (CPU_OUT.vector_taken)
      begin
        dep_q <= dep_q + 2'h1;
        rem_q[dep_q + 2'h1] <= isr_len;
      end
      else if (!CPU_OUT.call_active && wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (!CPU_OUT.call_active && dep_q != 2'h0 && rem_q[dep_q] == 4'h0)
      begin
        CORE_IN.return_from_isr <= 1'b1;
        dep_q <= dep_q - 2'h1;
        wait_q <= div_len - 4'h1;
      end
      else if (!CPU_OUT.call_active)
      begin
        CORE_IN.instr_done <= 1'b1;
        rem_q[dep_q] <= rem_q[dep_q] - 4'h1;
      end
    end
  end
endmodule // pih_core_model

// ---- testbench.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic ce = 1'b1;
  logic [21:0] ev = '0;
  logic pz = 1'b1;
  logic pe = 1'b1;
  logic [3:0] ilen = 4'h4;
  logic [3:0] dlen = 4'h1;
  logic irq;
  pih_pkg::pih_core_s core;
  pih_pkg::pih_cpu_s cpu;
  int error_cnt = 0;
  int checked = 0;
  int vcnt = 0;
  int cyc = 0;
  int tret = 0;
  int tvec = 0;
  logic [15:0] vq [$];
  logic [31:0] rq [$];
  always #50 mclk = ~mclk;
  pih_top i_pih_top (.MCLK(mclk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .SRC_EVENT(ev), .EXT_ZERO_PIN(pz), .ENABLE_PIN(pe),
    .CORE_IN(core), .IRQ_REQ(irq), .CPU_OUT(cpu));
  pih_core_model i_pih_core_model (.MCLK(mclk), .RST(rst), .isr_len(ilen), .div_len(dlen), .CPU_OUT(cpu),
    .CORE_IN(core));
  ////////////////////////////////////////
  always @(posedge mclk)
  begin : mon
    logic [31:0] x;
    cyc <= cyc + 1;
    if (psel && pen)
      `CHK("PSLVERR", padr > pih_pkg::OFF_STAT || padr[1:0] != 2'h0, perr)
    if (core.return_from_isr)
      tret <= cyc;
    if (psel && pen && !pwr)
    begin
      x = rq.pop_front();
      `CHK("PRDATA", x, prd)
    end
    if (cpu.vector_taken)
    begin
      x = vq.size() != 0 ? {16'h0, vq.pop_front()} : '1;
      vcnt <= vcnt + 1;
      tvec <= cyc;
      `CHK("vector", x, {16'h0, cpu.vector_addr})
    end
  end
  ////////////////////////////////////////
  function automatic logic [15:0] vec(input int k);
    return pih_pkg::VEC_BASE + 16'(k * 8);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    if (!w)
      rq.push_back(d);
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (!prdy)
      @(posedge mclk);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cfg(input logic [21:0] e, input logic [21:0] p, input logic g);
    apb(1'b1, pih_pkg::OFF_IE, {24'h0, g, e[6:0]});
    apb(1'b1, pih_pkg::OFF_IP, {25'h0, p[6:0]});
    apb(1'b1, pih_pkg::OFF_EIE1, {24'h0, e[14:7]});
    apb(1'b1, pih_pkg::OFF_EIP1, {24'h0, p[14:7]});
    apb(1'b1, pih_pkg::OFF_EIE2, {25'h0, e[21:15]});
    apb(1'b1, pih_pkg::OFF_EIP2, {25'h0, p[21:15]});
  endtask
  task automatic pulse(input logic [21:0] m);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
  endtask
  task automatic waitv(input int n);
    while (vcnt < n)
      @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    int k;
    int r;
    int n;
    int t;
    logic [21:0] m;
    logic [31:0] e;
    logic [31:0] f;
    void'($urandom(32'h1376));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, pih_pkg::OFF_IE, {24'h0, pih_pkg::IE_RESET});
    apb(1'b0, pih_pkg::OFF_IP, {24'h0, pih_pkg::IP_RESET});
    apb(1'b0, pih_pkg::OFF_TCTL, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    $display("test reset done");
    // Pending while gated off, then re-entry on a kept flag
    cfg(22'h8, 22'h0, 1'b0);
    pulse(22'h8);
    repeat (3) @(posedge mclk);
    `CHK("IRQ_REQ", 1'b0, irq)
    apb(1'b0, pih_pkg::OFF_PEND, 32'h8);
    vq.push_back(vec(3));
    vq.push_back(vec(3));
    apb(1'b1, pih_pkg::OFF_IE, 32'h88);
    waitv(2);
    apb(1'b1, pih_pkg::OFF_IE, 32'h0);
    apb(1'b1, pih_pkg::OFF_PEND, 32'h0);
    $display("test gate done");
    // Every vector by software set, random order
    apb(1'b1, pih_pkg::OFF_TCTL, 32'h5);
    r = $urandom % 22;
    for (int i = 0; i < 22; i++)
    begin
      k = (i * 7 + r) % 22;
      m = 22'h1 << k;
      cfg(m, 22'h0, 1'b1);
      vq.push_back(vec(k));
      n = vcnt;
      apb(1'b1, pih_pkg::OFF_PEND, {10'h0, m});
      waitv(n + 1);
      apb(1'b1, pih_pkg::OFF_IE, 32'h0);
      apb(1'b0, pih_pkg::OFF_PEND, pih_pkg::SELF_CLEAR[k] ? 32'h0 : {10'h0, m});
      apb(1'b1, pih_pkg::OFF_PEND, 32'h0);
    end
    $display("test vectors done");
    // Simultaneous: high first, then fixed order
    cfg(22'h108800, 22'h100000, 1'b1);
    vq.push_back(vec(20));
    vq.push_back(vec(11));
    vq.push_back(vec(15));
    n = vcnt;
    pulse(22'h108800);
    waitv(n + 3);
    $display("test order done");
    // External inputs, all sense and polarity choices
    cfg(22'h0, 22'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      {pe, pz} <= i[2] ? {!i[0], 1'b1} : {1'b1, !i[0]};
      @(posedge mclk);
      apb(1'b1, pih_pkg::OFF_EXTCFG, {30'h0, i[2] ? {i[0], 1'b0} : {1'b0, i[0]}});
      e = i[1] ? (i[2] ? 32'h4 : 32'h1) : 32'h0;
      f = i[2] ? 32'h8 : 32'h2;
      apb(1'b1, pih_pkg::OFF_TCTL, e);
      {pe, pz} <= i[2] ? {i[0], 1'b1} : {1'b1, i[0]};
      repeat (2) @(posedge mclk);
      apb(1'b0, pih_pkg::OFF_TCTL, e | f);
      {pe, pz} <= i[2] ? {!i[0], 1'b1} : {1'b1, !i[0]};
      repeat (2) @(posedge mclk);
      apb(1'b0, pih_pkg::OFF_TCTL, i[1] ? e | f : e);
    end
    $display("test pins done");
    // Preemption with fastest response
    ilen <= 4'hf;
    cfg(22'h20002, 22'h20000, 1'b1);
    vq.push_back(vec(1));
    vq.push_back(vec(17));
    n = vcnt;
    pulse(22'h2);
    waitv(n + 1);
    t = cyc;
    pulse(22'h20000);
    waitv(n + 2);
    // Event cycle, seven response clocks, taken strobe
    `CHK("latency", 9, tvec - t)
    repeat (40) @(posedge mclk);
    $display("test preempt done");
    // Equal level waits for return plus a divide
    ilen <= 4'h2;
    dlen <= 4'h8;
    cfg(22'h6, 22'h0, 1'b1);
    vq.push_back(vec(1));
    vq.push_back(vec(2));
    n = vcnt;
    pulse(22'h2);
    waitv(n + 1);
    pulse(22'h4);
    waitv(n + 2);
    `CHK("worst", 14, tvec - tret)
    $display("test worst done");
    // Clock enable low freezes flags and registers
    cfg(22'h0, 22'h0, 1'b0);
    apb(1'b1, pih_pkg::OFF_PEND, 32'h0);
    ce <= 1'b0;
    pulse(22'h10);
    apb(1'b1, pih_pkg::OFF_PEND, 32'h20);
    ce <= 1'b1;
    apb(1'b0, pih_pkg::OFF_PEND, 32'h0);
    $display("test enable done");
    report_and_stop();
  end
endmodule // testbench
